// >>> pwm_dual_counter.sv
// Dual-counter PWM timer: complementary, single-phase, buffered compare
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
// What this block does
// [RULE1] Paired counter turns down at cycle limit match, up at underflow.
// [RULE2] Software loads main counter above lagging counter before start.
// [RULE3] Duty at or above cycle limit, or zero, gives 0% or 100%.
// [RULE4] Reversal overshoots main counter, undershoots lagging counter.
// [RULE5] Complementary: match A flag on reversal, underflow flag on underflow.
// [RULE6] No overflow flag on complementary wrap with prescale 1 or 2.
// [RULE7] Software keeps compare values inside the dead-time window.
// [RULE8] Software loads buffers equal to compare registers first.
// [RULE9] Software changes duty only via buffers, never the cycle limit.
// [RULE10] Single-phase mode forces pins A0, B0 to PWM outputs.
// [RULE11] Pin A0: A0 match drives level, A1 match drives opposite.
// [RULE12] Pin B0: B0 match drives level, B1 match drives opposite.
// [RULE13] Unused pins released; C and D still match lagging counter.
// [RULE14] Single-phase select low picks mode; clear select 001 clears.
// [RULE15] Buffer C pairs with compare A, buffer D with compare B.
// [RULE16] Output compare match copies buffer into compare register.
// [RULE17] Capture loads counter, old compare value moves into buffer.
// [RULE18] Single-phase: cycle limit match copies every buffer.
// [RULE19] Complementary: copies only at the two reversal points.
// [RULE20] Copy lands on the same edge as its triggering event.
module pwm_dual_counter (
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     ce_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [7:0]               paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire logic                     capture_in,
  output pwm_timer_pkg::pin_bank_t      pin_level_out,
  output pwm_timer_pkg::pin_bank_t      pin_oe_out
);
  localparam int W = pwm_timer_pkg::COUNTER_W;

  logic [6:0]                 counter_ctrl_q;
  logic [3:0]                 mode_ctrl_q;
  logic                       function_ctrl_q;
  logic [1:0]                 output_level_ctrl_q;
  pwm_timer_pkg::flags_t      flags_q;
  logic [W-1:0]               main_counter_q;
  logic [W-1:0]               lagging_counter_q;
  pwm_timer_pkg::count_dir_t  dir_q;
  logic                       cap_s1_q;
  logic                       cap_s2_q;
  logic                       cap_s3_q;

  wire        bus_access = psel_in & penable_in;
  wire        bus_commit = bus_access & pready_out;
  wire        addr_ok    = (paddr_in[1:0] == 2'h0) & (paddr_in[7:6] == 2'h0)
                         & (paddr_in[5:2] <= pwm_timer_pkg::LAST_WORD_IDX);
  wire        wr         = bus_commit & pwrite_in & addr_ok;
  wire        wr_cctrl   = wr & (paddr_in == pwm_timer_pkg::OFS_COUNTER_CTRL);
  wire        wr_mode    = wr & (paddr_in == pwm_timer_pkg::OFS_MODE_CTRL);
  wire        wr_func    = wr & (paddr_in == pwm_timer_pkg::OFS_FUNCTION_CTRL);
  wire        wr_level   = wr &
                           (paddr_in == pwm_timer_pkg::OFS_OUTPUT_LEVEL_CTRL);
  wire        wr_status  = wr & (paddr_in == pwm_timer_pkg::OFS_STATUS);
  wire        wr_main    = wr & (paddr_in == pwm_timer_pkg::OFS_MAIN_COUNTER);
  wire        wr_lag     = wr &
                           (paddr_in == pwm_timer_pkg::OFS_LAGGING_COUNTER);
  wire [W-1:0] wdata     = pwdata_in[W-1:0];

  wire [2:0]  clear_sel  = counter_ctrl_q[pwm_timer_pkg::CCLR_LSB +: 3];
  wire [2:0]  psc_sel    = counter_ctrl_q[pwm_timer_pkg::PSC_LSB +: 3];
  wire        running    = counter_ctrl_q[pwm_timer_pkg::START_BIT];
  wire        buf_a_en   = mode_ctrl_q[pwm_timer_pkg::BUF_A_BIT];
  wire        buf_b_en   = mode_ctrl_q[pwm_timer_pkg::BUF_B_BIT];
  wire        compl_sel  = mode_ctrl_q[pwm_timer_pkg::COMPL_BIT];
  wire        cap_mode   = mode_ctrl_q[pwm_timer_pkg::CAPTURE_BIT];
  wire        level_a    = output_level_ctrl_q[pwm_timer_pkg::LEVEL_A_BIT];
  wire        level_b    = output_level_ctrl_q[pwm_timer_pkg::LEVEL_B_BIT];

  wire        single_sel = ~compl_sel & ~function_ctrl_q;  // see [RULE14]
  pwm_timer_pkg::timer_mode_t mode;
  assign mode = compl_sel  ? pwm_timer_pkg::MODE_COMPL  :
                single_sel ? pwm_timer_pkg::MODE_SINGLE :
                             pwm_timer_pkg::MODE_NORMAL;
  wire        in_compl   = mode == pwm_timer_pkg::MODE_COMPL;
  wire        in_single  = mode == pwm_timer_pkg::MODE_SINGLE;
  wire        in_normal  = mode == pwm_timer_pkg::MODE_NORMAL;

  logic tick;
  pwm_tick_gen #(
    .SEL_W (3)
  ) u_tick (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .sel_in   (psc_sel),
    .tick_out (tick)
  );

  wire        step = ce_in & running & tick;

  // Index 0..3: A0, B0, A1, B1; each pairs with C0, D0, C1, D1
  logic [W-1:0] gr   [4];
  logic [W-1:0] bufr [4];
  logic [3:0]   xfer;
  logic [3:0]   unit_match;

  // Capture edge: first stage feeds only the second
  wire        cap_edge = cap_s2_q & ~cap_s3_q;
  wire        cap_evt  = ce_in & in_normal & cap_mode & cap_edge;
  wire        match_a0 = main_counter_q == gr[0];
  wire        rev_top  = step & in_compl & (dir_q == pwm_timer_pkg::DIR_UP)
                       & match_a0;                        // see [RULE1]
  wire        rev_bot  = step & in_compl & (dir_q == pwm_timer_pkg::DIR_DOWN)
                       & (lagging_counter_q == '0);       // see [RULE1]
  wire        clear_a0 = step & ~in_compl & match_a0
                       & (clear_sel == pwm_timer_pkg::CLEAR_ON_A0);
  wire        xfer_all = in_compl  ? (rev_top | rev_bot) :   // see [RULE19]
                         in_single ? (step & match_a0) :     // see [RULE18]
                                     1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_unit
      localparam logic [7:0] GR_OFS  =
        8'(pwm_timer_pkg::OFS_GR_BASE + 8'(4 * gi));
      localparam logic [7:0] BUF_OFS =
        8'(pwm_timer_pkg::OFS_BUF_BASE + 8'(4 * gi));
      wire [W-1:0] own_cnt = (gi < 2 || in_single) ? main_counter_q
                                                   : lagging_counter_q;
      wire         cap_i   = (gi == 0) & cap_evt;
      wire         buf_en  = (gi % 2 == 0) ? buf_a_en
                                           : buf_b_en;  // see [RULE15]
      assign unit_match[gi] = own_cnt == gr[gi];
      // Output compare: each register reloads on its own match
      assign xfer[gi] = xfer_all |
                        (step & in_normal & ~(cap_mode & (gi == 0))
                         & unit_match[gi]);               // see [RULE16]
      pwm_gr_unit #(
        .W (W)
      ) u_gr (
        .clk_in     (clk_in),
        .reset_in   (reset_in),
        .ce_in      (ce_in),
        .buf_en_in  (buf_en),
        .xfer_in    (xfer[gi]),
        .capture_in (cap_i),
        .count_in   (main_counter_q),
        .wr_gr_in   (wr & (paddr_in == GR_OFS)),
        .wr_buf_in  (wr & (paddr_in == BUF_OFS)),
        .wdata_in   (wdata),
        .gr_out     (gr[gi]),
        .buf_out    (bufr[gi])
      );
    end
  endgenerate

  wire        going_up = dir_q == pwm_timer_pkg::DIR_UP;
  // Reversal step still moves one count past the turning point
  wire [W-1:0] main_d =
    wr_main           ? wdata :
    ~step             ? main_counter_q :
    in_compl          ? (going_up ? main_counter_q + 1'b1
                                  : main_counter_q - 1'b1) :  // see [RULE4]
    clear_a0          ? '0 : main_counter_q + 1'b1;           // see [RULE14]
  wire [W-1:0] lag_d =
    wr_lag            ? wdata :
    ~step             ? lagging_counter_q :
    (in_compl & ~going_up) ? lagging_counter_q - 1'b1         // see [RULE4]
                           : lagging_counter_q + 1'b1;
  pwm_timer_pkg::count_dir_t dir_d;
  assign dir_d = ~in_compl ? pwm_timer_pkg::DIR_UP   :
                 rev_top   ? pwm_timer_pkg::DIR_DOWN :
                 rev_bot   ? pwm_timer_pkg::DIR_UP   : dir_q;

  wire        fast_psc = psc_sel <= pwm_timer_pkg::PSC_HALF;
  wire        ovf_evt  = step & (in_compl
                 ? (going_up & ~fast_psc
                    & (lagging_counter_q == pwm_timer_pkg::COUNT_TOP))
                 : (~clear_a0
                    & (main_counter_q == pwm_timer_pkg::COUNT_TOP)));
  pwm_timer_pkg::flags_t flag_set;
  assign flag_set.match_a0  = in_compl ? (rev_top | rev_bot)  // see [RULE5]
                                       : (step & match_a0);
  assign flag_set.underflow = rev_bot;                        // see [RULE5]
  assign flag_set.overflow  = ovf_evt;                        // see [RULE6]
  assign flag_set.match_b0  = step & ~in_compl & unit_match[1];
  // Without buffering, C1 and D1 compare against the lagging counter
  assign flag_set.match_c1  = step & ~in_compl & ~buf_a_en
                            & (lagging_counter_q == bufr[2]); // see [RULE13]
  assign flag_set.match_d1  = step & ~in_compl & ~buf_b_en
                            & (lagging_counter_q == bufr[3]); // see [RULE13]
  wire [5:0]  flag_clr = wr_status ? pwdata_in[5:0] : 6'h00;
  // Set beats a write-one clear in the same cycle
  wire [5:0]  flags_d  = (flags_q & ~flag_clr) | flag_set;

  // Normal phase follows the lagging counter, counter phase the main
  // one; the dead time between them needs main above lagging (see [RULE2])
  function automatic logic [1:0] phase_pair(
    input logic [W-1:0] duty,
    input logic [W-1:0] limit,
    input logic [W-1:0] lead,
    input logic [W-1:0] lag
  );
    logic [1:0] r;
    r = 2'b00;
    if (duty == '0)          r = 2'b10;                // see [RULE3]
    else if (duty >= limit)  r = 2'b01;                // see [RULE3]
    else                     r = {lag >= duty, lead < duty};
    return r;
  endfunction : phase_pair

  wire [1:0]  ph1 = phase_pair(gr[1], gr[0], main_counter_q,
                               lagging_counter_q);
  wire [1:0]  ph2 = phase_pair(gr[2], gr[0], main_counter_q,
                               lagging_counter_q);
  wire [1:0]  ph3 = phase_pair(gr[3], gr[0], main_counter_q,
                               lagging_counter_q);

  wire        a0_on  = step & unit_match[2];
  wire        b0_on  = step & unit_match[3];
  wire        b0_off = step & unit_match[1];
  pwm_timer_pkg::pin_bank_t pin_d;
  pwm_timer_pkg::pin_bank_t oe_d;
  always_comb begin
    pin_d = pin_level_out;
    oe_d  = '0;
    unique case (mode)
      pwm_timer_pkg::MODE_COMPL: begin
        pin_d.b0 = ph1[1];
        pin_d.d0 = ph1[0];
        pin_d.a1 = ph2[1];
        pin_d.c1 = ph2[0];
        pin_d.b1 = ph3[1];
        pin_d.d1 = ph3[0];
        if (rev_top) pin_d.c0 = ~pin_level_out.c0;
        oe_d     = 8'hFE;
      end
      pwm_timer_pkg::MODE_SINGLE: begin
        // Cycle limit match has the last word on pin A0
        if (step & match_a0) pin_d.a0 = level_a;        // see [RULE11]
        else if (a0_on)      pin_d.a0 = ~level_a;       // see [RULE11]
        if (b0_off)          pin_d.b0 = level_b;        // see [RULE12]
        else if (b0_on)      pin_d.b0 = ~level_b;       // see [RULE12]
        oe_d.a0 = 1'b1;                                 // see [RULE10]
        oe_d.b0 = 1'b1;                                 // see [RULE10]
      end
      pwm_timer_pkg::MODE_NORMAL: begin
        oe_d = '0;                                      // see [RULE13]
      end
    endcase
  end

  logic [31:0] rd_words [16];
  assign rd_words[0]  = {25'h0, counter_ctrl_q};
  assign rd_words[1]  = {28'h0, mode_ctrl_q};
  assign rd_words[2]  = {31'h0, function_ctrl_q};
  assign rd_words[3]  = {30'h0, output_level_ctrl_q};
  assign rd_words[4]  = {26'h0, flags_q};
  assign rd_words[5]  = {16'h0, main_counter_q};
  assign rd_words[6]  = {16'h0, lagging_counter_q};
  assign rd_words[15] = 32'h0;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rd
      assign rd_words[7 + gi]  = {16'h0, gr[gi]};
      assign rd_words[11 + gi] = {16'h0, bufr[gi]};
    end
  endgenerate
  wire [31:0] rdata = addr_ok ? rd_words[paddr_in[5:2]] : 32'h0;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end else if (ce_in) begin
      // One wait state: ready rises in the second access cycle
      pready_out  <= bus_access & ~pready_out;
      pslverr_out <= bus_access & ~pready_out & ~addr_ok;
      if (bus_access & ~pready_out & ~pwrite_in) prdata_out <= rdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      counter_ctrl_q      <= pwm_timer_pkg::COUNTER_CTRL_RST;
      mode_ctrl_q         <= pwm_timer_pkg::MODE_CTRL_RST;
      function_ctrl_q     <= pwm_timer_pkg::FUNCTION_CTRL_RST;
      output_level_ctrl_q <= pwm_timer_pkg::LEVEL_CTRL_RST;
    end else if (ce_in) begin
      if (wr_cctrl) counter_ctrl_q      <= pwdata_in[6:0];
      if (wr_mode)  mode_ctrl_q         <= pwdata_in[3:0];
      if (wr_func)  function_ctrl_q     <= pwdata_in[0];
      if (wr_level) output_level_ctrl_q <= pwdata_in[1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      main_counter_q    <= '0;
      lagging_counter_q <= '0;
      dir_q             <= pwm_timer_pkg::DIR_UP;
      flags_q           <= '0;
      pin_level_out     <= '0;
      pin_oe_out        <= '0;
      cap_s1_q          <= 1'b0;
      cap_s2_q          <= 1'b0;
      cap_s3_q          <= 1'b0;
    end else if (ce_in) begin
      main_counter_q    <= main_d;
      lagging_counter_q <= lag_d;
      dir_q             <= dir_d;
      flags_q           <= flags_d;
      pin_level_out     <= pin_d;
      pin_oe_out        <= oe_d;
      cap_s1_q          <= capture_in;
      cap_s2_q          <= cap_s1_q;
      cap_s3_q          <= cap_s2_q;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_turn_at_top: assert property ( // see [RULE1]
    rev_top & ~wr_main |=> dir_q == pwm_timer_pkg::DIR_DOWN
      && main_counter_q == $past(main_counter_q) + 16'h0001)
    else $error("no turn down with overshoot at cycle limit");
  a_turn_at_bottom: assert property ( // see [RULE4]
    rev_bot & ~wr_lag |=> dir_q == pwm_timer_pkg::DIR_UP
      && lagging_counter_q == 16'hFFFF)
    else $error("no turn up with undershoot at underflow");
  a_duty_zero_pct: assert property ( // see [RULE3]
    ce_in && in_compl && gr[1] != 16'h0000 && gr[1] >= gr[0]
      |=> !pin_level_out.b0 && pin_level_out.d0)
    else $error("duty at cycle limit not held at 0 percent");
  a_reversal_flags: assert property ( // see [RULE5]
    rev_bot |=> flags_q.match_a0 && flags_q.underflow)
    else $error("reversal at underflow did not set both flags");
  a_no_fast_overflow: assert property ( // see [RULE6]
    ce_in && in_compl && fast_psc && !flags_q.overflow
      |=> !flags_q.overflow)
    else $error("overflow flag set with fast prescale");
  a_single_pin_drive: assert property ( // see [RULE10]
    ce_in && in_single |=> pin_oe_out.a0 && pin_oe_out.b0
      && !pin_oe_out.c0)
    else $error("single-phase mode did not drive pins A0 and B0");
  a_pin_a_levels: assert property ( // see [RULE11]
    in_single && step && match_a0
      |=> pin_level_out.a0 == $past(level_a))
    else $error("pin A0 wrong after cycle limit match");
  a_pin_b_levels: assert property ( // see [RULE12]
    in_single && step && unit_match[1]
      |=> pin_level_out.b0 == $past(level_b))
    else $error("pin B0 wrong after B0 match");
  a_clear_on_limit: assert property ( // see [RULE14]
    clear_a0 && !wr_main |=> main_counter_q == 16'h0000)
    else $error("main counter not cleared on cycle limit match");
  a_capture_shift: assert property ( // see [RULE17]
    cap_evt && buf_a_en |=> gr[0] == $past(main_counter_q)
      && bufr[0] == $past(gr[0]))
    else $error("capture did not shift old value into buffer");
  a_reversal_copy: assert property ( // see [RULE19]
    (rev_top || rev_bot) && buf_a_en |=> gr[2] == $past(bufr[2]))
    else $error("buffer not copied at reversal");
endmodule : pwm_dual_counter

// >>> pwm_timer_pkg.sv
// Shared constants and types for the dual-counter PWM timer
package pwm_timer_pkg;
  localparam int COUNTER_W = 16;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_COUNTER_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MODE_CTRL         = 8'h04;
  localparam logic [7:0] OFS_FUNCTION_CTRL     = 8'h08;
  localparam logic [7:0] OFS_OUTPUT_LEVEL_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STATUS            = 8'h10;
  localparam logic [7:0] OFS_MAIN_COUNTER      = 8'h14;
  localparam logic [7:0] OFS_LAGGING_COUNTER   = 8'h18;
  localparam logic [7:0] OFS_GR_BASE           = 8'h1C;
  localparam logic [7:0] OFS_BUF_BASE          = 8'h2C;
  localparam logic [3:0] LAST_WORD_IDX         = 4'hE;

  // counter_ctrl fields
  localparam int CCLR_LSB  = 0;
  localparam int PSC_LSB   = 3;
  localparam int START_BIT = 6;
  // mode_ctrl fields
  localparam int BUF_A_BIT   = 0;
  localparam int BUF_B_BIT   = 1;
  localparam int COMPL_BIT   = 2;
  localparam int CAPTURE_BIT = 3;
  // function_ctrl and output_level_ctrl fields
  localparam int SINGLE_SEL_BIT = 0;
  localparam int LEVEL_A_BIT    = 0;
  localparam int LEVEL_B_BIT    = 1;

  localparam logic [2:0]  CLEAR_ON_A0 = 3'h1;
  localparam logic [2:0]  PSC_HALF    = 3'h1;
  localparam logic [6:0]  COUNTER_CTRL_RST  = 7'h00;
  localparam logic [3:0]  MODE_CTRL_RST     = 4'h0;
  localparam logic        FUNCTION_CTRL_RST = 1'b1;
  localparam logic [1:0]  LEVEL_CTRL_RST    = 2'h0;
  localparam logic [15:0] GR_RST            = 16'hFFFF;
  localparam logic [15:0] COUNT_TOP         = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SINGLE = 3'b010,
    MODE_COMPL  = 3'b100
  } timer_mode_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_t;

  typedef struct packed {
    logic d1;
    logic c1;
    logic b1;
    logic a1;
    logic d0;
    logic c0;
    logic b0;
    logic a0;
  } pin_bank_t;

  typedef struct packed {
    logic match_d1;
    logic match_c1;
    logic match_b0;
    logic overflow;
    logic underflow;
    logic match_a0;
  } flags_t;
endpackage : pwm_timer_pkg

// >>> pwm_tick_gen.sv
// Timer clock prescaler: one-cycle tick every 2**select clocks
`timescale 1ns/1ps
module pwm_tick_gen #(
  parameter int SEL_W = 3
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic [SEL_W-1:0] sel_in,
  output logic                  tick_out
);
  localparam int DIV_W = (1 << SEL_W) - 1;

  generate
    if (SEL_W < 1 || SEL_W > 4) begin : g_bad_width
      $error("pwm_tick_gen: SEL_W must be 1 to 4");
    end
  endgenerate

  logic [DIV_W-1:0] count_q;
  wire  [DIV_W-1:0] mask = ~({DIV_W{1'b1}} << sel_in);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_q  <= '0;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      count_q  <= count_q + 1'b1;
      tick_out <= (count_q & mask) == mask;
    end
  end
endmodule : pwm_tick_gen

// >>> pwm_gr_unit.sv
// One compare/capture register with its paired buffer register
`timescale 1ns/1ps
module pwm_gr_unit #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire logic         ce_in,
  input  wire logic         buf_en_in,
  input  wire logic         xfer_in,
  input  wire logic         capture_in,
  input  wire logic [W-1:0] count_in,
  input  wire logic         wr_gr_in,
  input  wire logic         wr_buf_in,
  input  wire logic [W-1:0] wdata_in,
  output logic      [W-1:0] gr_out,
  output logic      [W-1:0] buf_out
);
  generate
    if (W != pwm_timer_pkg::COUNTER_W) begin : g_bad_width
      $error("pwm_gr_unit: W must match the counter width");
    end
  endgenerate

  // Hardware events win over a software write in the same cycle
  wire          shift_buf = capture_in & buf_en_in;
  wire          load_buf  = xfer_in & buf_en_in & ~capture_in;
  wire [W-1:0]  gr_d  = capture_in ? count_in :
                        load_buf   ? buf_out  :
                        wr_gr_in   ? wdata_in : gr_out;
  wire [W-1:0]  buf_d = shift_buf ? gr_out :
                        wr_buf_in ? wdata_in : buf_out;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gr_out  <= pwm_timer_pkg::GR_RST;
      buf_out <= pwm_timer_pkg::GR_RST;
    end else if (ce_in) begin
      gr_out  <= gr_d;   // see [RULE20] see [RULE16] see [RULE17]
      buf_out <= buf_d;  // see [RULE17]
    end
  end
endmodule : pwm_gr_unit

// >>> pwm_pin_load.sv
// Model of the drive circuits hanging on the timer pins
`timescale 1ns/1ps
module pwm_pin_load (
  input  wire pwm_timer_pkg::pin_bank_t level_in,
  input  wire pwm_timer_pkg::pin_bank_t oe_in,
  output pwm_timer_pkg::pin_bank_t      pad_out
);
  // Released pins act as port pins with a pull-down
  assign pad_out = level_in & oe_in;
endmodule : pwm_pin_load

// >>> pwm_dual_counter_tb.sv
// Self-checking bench for the dual-counter PWM timer
`timescale 1ns/1ps
module pwm_dual_counter_tb;
  logic                     clk_in = 1'b0;
  logic                     reset_in = 1'b1;
  logic                     psel = 1'b0;
  logic                     pen = 1'b0;
  logic                     pwr = 1'b0;
  logic [7:0]               pa = 8'h00;
  logic [31:0]              pwd = 32'h0;
  logic [31:0]              prd;
  logic [31:0]              r;
  logic                     rdy;
  logic                     err;
  logic                     e;
  logic                     cap = 1'b0;
  pwm_timer_pkg::pin_bank_t lvl;
  pwm_timer_pkg::pin_bank_t oe;
  pwm_timer_pkg::pin_bank_t pad;
  int                       n_errors = 0;
  int                       n_checks = 0;
  int                       n;
  int                       bad;
  int                       v[4] = '{24, 22, 6, 10};
  always #5 clk_in = ~clk_in;
  pwm_dual_counter i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .ce_in(1'b1), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .capture_in(cap), .pin_level_out(lvl),
    .pin_oe_out(oe));
  pwm_pin_load i_load (.level_in(lvl), .oe_in(oe), .pad_out(pad));
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic wn, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwr  <= wn;
    pa   <= a;
    pwd  <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (rdy !== 1'b1 && k < 16);
    if (rdy !== 1'b1) chk("pready", 1'b1, rdy);
    r = prd;
    e = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask : rc
  // Counts one whole run of level lv on pad bit b
  task automatic width(input int b, input logic lv);
    n = 0;
    while (pad[b] === lv && n < 400) begin @(posedge clk_in); n++; end
    while (pad[b] !== lv && n < 800) begin @(posedge clk_in); n++; end
    n = 0;
    while (pad[b] === lv && n < 400) begin @(posedge clk_in); n++; end
  endtask : width
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    rc("function_ctrl", 8'h08, 32'h1);
    rc("cycle_limit_reg", pwm_timer_pkg::OFS_GR_BASE, 32'hFFFF);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped pslverr", 1'b1, e);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(pwm_timer_pkg::OFS_GR_BASE + 8'(4 * i), v[i]);
      wr(pwm_timer_pkg::OFS_BUF_BASE + 8'(4 * i), v[i]);
    end
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h41);
    width(0, 1'b1);
    chk("a0 high", 18, n);
    width(1, 1'b1);
    chk("b0 high", 12, n);
    wr(8'h0C, 32'h3);
    width(0, 1'b0);
    chk("a0 low", 18, n);
    width(1, 1'b0);
    chk("b0 low", 12, n);
    chk("single oe", 8'h03, oe);
    wr(pwm_timer_pkg::OFS_BUF_BASE + 8'h08, 32'h4);
    repeat (60) @(posedge clk_in);
    width(0, 1'b0);
    chk("a0 low buffered", 20, n);
    rc("phase2_compare_reg", 8'h24, 32'h4);
    $display("single-phase test done");
    wr(8'h00, 32'h0);
    // Main above lagging, compares in window
    v = '{40, 20, 10, 30};
    for (int i = 0; i < 4; i++) begin
      wr(pwm_timer_pkg::OFS_GR_BASE + 8'(4 * i), v[i]);
      wr(pwm_timer_pkg::OFS_BUF_BASE + 8'(4 * i), v[i]);
    end
    wr(8'h14, 32'h4);
    wr(8'h18, 32'h0);
    wr(8'h10, 32'h3F);
    wr(8'h04, 32'h7);
    wr(8'h00, 32'h40);
    repeat (300) @(posedge clk_in);
    apb(1'b0, 8'h10, 32'h0);
    chk("turn flags", 32'h3, r & 32'h7);
    apb(1'b0, 8'h14, 32'h0);
    chk("main bounded", 1'b1, r <= 32'd41);
    chk("compl oe", 8'hFE, oe);
    // Duty changed through the buffer only
    for (int i = 0; i < 2; i++) begin
      wr(8'h30, i ? 32'd40 : 32'd0);
      repeat (300) @(posedge clk_in);
      bad = 0;
      repeat (200) begin
        @(posedge clk_in);
        if (pad.b0 !== (i == 0) || pad.d0 !== (i != 0)) bad++;
      end
      chk("flat duty", 0, bad);
    end
    $display("complementary test done");
    // Counter stopped, so the captured count is known
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h04, 32'h9);
    wr(8'h14, 32'h123);
    wr(pwm_timer_pkg::OFS_BUF_BASE, 32'h7);
    cap <= 1'b1;
    repeat (6) @(posedge clk_in);
    cap <= 1'b0;
    rc("capture a0", pwm_timer_pkg::OFS_GR_BASE, 32'h123);
    rc("capture c0", pwm_timer_pkg::OFS_BUF_BASE, 32'd40);
    $display("capture test done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : pwm_dual_counter_tb
